// [hdl/scet_sensor_dev.sv]
// device end: control word, training pattern, exposure and readout sequencer, serialisers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - control bits 0-2 flag pixel, row, frame
// - bit3 overhead, bits 4-5 integration blocks
// - control word length follows depth; constants
// - idle control word is bit7 only
// - receiver qualifies pixels by valid flags only
// - fewer lanes stretch row time and flags
// - training word fills all non-pixel data slots
// - primary training word loaded at address 89
// - secondary word: low 8 inverted, top zero
// - secondary word just before each row start
// - row valid without pixel: primary only
// - receiver realigns on the idle control word
// - address 70 picks internal or external exposure
// - external exposure: start pin to request
// - internal exposure length formula, 24-bit count
// - external interval quantised plus overlap
// - line time is setting plus one words
// - overhead lines setting plus two; readout lines
// - readout lines halved subsampled, quartered binned
// - frames per request, internal mode only
// - words sent lsb first, bit0 clock high
// - one word gap between pixel bursts
module scet_sensor_dev #(
   parameter int LANES = 64,
   parameter int BIT_CYC = scet_pkg::BIT_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // sensor link
   scet_link_if.dev lnk,
   // user side status
   output logic frame_busy
);
   localparam int CW = scet_pkg::CW;

   // pins from the controller pass two flops before use
   logic [2:0] wr_s;
   logic [2:0] te_s;
   logic [2:0] fr_s;
   logic [6:0] wa_s1;
   logic [6:0] wa_s2;
   logic [15:0] wd_s1;
   logic [15:0] wd_s2;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_s <= 3'h0;
         te_s <= 3'h0;
         fr_s <= 3'h0;
         wa_s1 <= 7'h00;
         wa_s2 <= 7'h00;
         wd_s1 <= 16'h0000;
         wd_s2 <= 16'h0000;
      end else begin
         wr_s <= {wr_s[1:0], lnk.reg_wr_tgl};
         te_s <= {te_s[1:0], lnk.exposure_start_pin};
         fr_s <= {fr_s[1:0], lnk.frame_req_pin};
         wa_s1 <= lnk.reg_addr;
         wa_s2 <= wa_s1;
         wd_s1 <= lnk.reg_wdata;
         wd_s2 <= wd_s1;
      end
   end
   // address and data are held long before the toggle moves, so the pair is stable here
   wire wr_ev = wr_s[2] ^ wr_s[1];
   wire te_rise = te_s[1] & ~te_s[2];
   wire fr_rise = fr_s[1] & ~fr_s[2];

   // sequencer registers
   logic [15:0] lines_r;
   logic [7:0] exp_mode_r;
   logic [15:0] exp_lo_r;
   logic [7:0] exp_hi_r;
   logic [15:0] frames_r;
   logic [3:0] lanes_r;
   logic [15:0] ovh_r;
   logic [15:0] line_r;
   logic [11:0] tp_r;
   logic [1:0] depth_r;
   logic [1:0] rdmode_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lines_r <= scet_pkg::R_LINES;
         exp_mode_r <= scet_pkg::R_EXP_MODE;
         exp_lo_r <= scet_pkg::R_EXP_LO;
         exp_hi_r <= scet_pkg::R_EXP_HI;
         frames_r <= scet_pkg::R_FRAMES;
         lanes_r <= scet_pkg::R_LANES;
         ovh_r <= scet_pkg::R_OVH;
         line_r <= scet_pkg::R_LINE;
         tp_r <= scet_pkg::R_TP;
         depth_r <= scet_pkg::R_DEPTH;
         rdmode_r <= scet_pkg::R_RDMODE;
      end else if (wr_ev) begin
         case (wa_s2)
            scet_pkg::A_LINES: lines_r <= wd_s2;
            scet_pkg::A_EXP_MODE: exp_mode_r <= wd_s2[7:0];
            scet_pkg::A_EXP_LO: exp_lo_r <= wd_s2;
            scet_pkg::A_EXP_HI: exp_hi_r <= wd_s2[7:0];
            scet_pkg::A_FRAMES: frames_r <= wd_s2;
            scet_pkg::A_LANES: lanes_r <= wd_s2[3:0];
            scet_pkg::A_OVH: ovh_r <= wd_s2;
            scet_pkg::A_LINE: line_r <= wd_s2;
            scet_pkg::A_TP: tp_r <= wd_s2[11:0];
            scet_pkg::A_DEPTH: depth_r <= wd_s2[1:0];
            scet_pkg::A_RDMODE: rdmode_r <= wd_s2[1:0];
            default: ;
         endcase
      end
   end

   // derived lengths; slot, readout, overhead and exposure lengths counted in word periods
   logic [3:0] wl;
   assign wl = (depth_r == scet_pkg::DEP_8) ? 4'h8 : (depth_r == scet_pkg::DEP_10) ? 4'hA : 4'hC;
   wire ext = exp_mode_r[0];
   wire [2:0] lg = lanes_r[2:0];
   wire one_side = lanes_r[3];
   wire [16:0] lp1 = {1'b0, line_r} + 17'h0_0001;
   wire [22:0] slot = 23'(lp1) << lg;
   wire [12:0] row_valid_flag_len = 13'((14'h0081 << lg) - 14'h0001);
   wire [1:0] rsh = (rdmode_r == 2'h1) ? 2'h1 : (rdmode_r == 2'h2) ? 2'h2 : 2'h0;
   wire [15:0] rows = (lines_r >> rsh) >> (one_side ? 1'b0 : 1'b1);
   wire [CW-1:0] ro_len = CW'(rows) * CW'(slot);
   wire [CW-1:0] fot_len = (CW'(ovh_r[15:8]) + CW'(scet_pkg::FOT_ADD)) * CW'(lp1);
   wire [CW-1:0] ov = CW'(scet_pkg::OV_MULT) * CW'(ovh_r[7:0]);
   wire [23:0] ecount = {exp_hi_r, exp_lo_r} - 24'h00_0001;
   wire [CW-1:0] exp_len = CW'(ecount) * CW'(lp1) + ov + CW'(1);

   // bit and word timing; a word ends on the last bit of the selected depth
   logic [7:0] bc_r;
   logic [3:0] bi_r;
   wire bit_end = (bc_r == 8'(BIT_CYC - 1));
   wire wt = bit_end && (bi_r >= wl - 4'h1);

   // sequencer state
   logic [CW-1:0] ro_left_r;
   logic [CW-1:0] ro_left_nxt;
   logic [CW-1:0] exp_cnt_r;
   logic [CW-1:0] exp_cnt_nxt;
   logic [22:0] off_r;
   logic [22:0] off_nxt;
   logic [15:0] row_r;
   logic [15:0] row_nxt;
   logic [7:0] bpos_r;
   logic [7:0] bpos_nxt;
   logic [15:0] frames_left_r;
   logic [15:0] frames_left_nxt;
   logic fot_pend_r;
   logic fot_pend_nxt;
   logic ext_wait_r;
   logic ext_wait_nxt;
   logic te_pend_r;
   logic te_pend_nxt;
   logic fr_pend_r;
   logic fr_pend_nxt;

   // status of the word about to be sent
   wire frame_overhead = ro_left_r > ro_len;
   wire rd = (ro_left_r != '0) && !frame_overhead;
   wire row_valid_flag = rd && (off_r < 23'(row_valid_flag_len));
   wire pixel_valid_flag = row_valid_flag && (bpos_r != 8'(scet_pkg::BURST));
   wire frame_valid_flag = rd && ((row_r + 16'h0001 < rows) || row_valid_flag);
   wire integ = exp_cnt_r != '0;
   wire last_row = !(row_r + 16'h0001 < rows);
   wire tp2_sel = (frame_overhead && ro_left_r == ro_len + CW'(1)) ||
      (rd && off_r == slot - 23'h00_0001 && !last_row);
   // the overhead only starts once the previous readout is fully out
   wire fot_go = fot_pend_r && !ext_wait_r && exp_cnt_r <= ov && ro_left_r == '0;

   // sequencer next state, stepped once per word period
   always_comb begin
      ro_left_nxt = ro_left_r;
      exp_cnt_nxt = exp_cnt_r;
      off_nxt = off_r;
      row_nxt = row_r;
      bpos_nxt = bpos_r;
      frames_left_nxt = frames_left_r;
      fot_pend_nxt = fot_pend_r;
      ext_wait_nxt = ext_wait_r;
      te_pend_nxt = te_pend_r | te_rise;
      fr_pend_nxt = fr_pend_r | fr_rise;
      if (wt) begin
         // a pin edge arriving in the consuming cycle is kept for the next word
         te_pend_nxt = te_rise;
         fr_pend_nxt = fr_rise;
         if (fot_go) begin
            ro_left_nxt = fot_len + ro_len;
            off_nxt = 23'h00_0000;
            row_nxt = 16'h0000;
            bpos_nxt = 8'h00;
            fot_pend_nxt = 1'b0;
         end else if (ro_left_r != '0) begin
            ro_left_nxt = ro_left_r - CW'(1);
            if (rd && off_r == slot - 23'h00_0001) begin
               off_nxt = 23'h00_0000;
               row_nxt = row_r + 16'h0001;
               bpos_nxt = 8'h00;
            end else if (rd) begin
               off_nxt = off_r + 23'h00_0001;
               bpos_nxt = (bpos_r == 8'(scet_pkg::BURST)) ? 8'h00 : bpos_r + 8'h01;
            end
         end
         if (integ && !ext_wait_r) begin
            exp_cnt_nxt = exp_cnt_r - CW'(1);
         end
         if (ext) begin
            if (fr_pend_r && ext_wait_r) begin
               ext_wait_nxt = 1'b0;
               exp_cnt_nxt = ov;
            end else if (te_pend_r && !fot_pend_r && !integ) begin
               ext_wait_nxt = 1'b1;
               fot_pend_nxt = 1'b1;
               exp_cnt_nxt = CW'(1);
            end
         end else if (fr_pend_r) begin
            frames_left_nxt = frames_r;
         end else if (frames_left_r != 16'h0000 && !fot_pend_r && !integ && ro_left_r <= exp_len - ov) begin
            frames_left_nxt = frames_left_r - 16'h0001;
            fot_pend_nxt = 1'b1;
            exp_cnt_nxt = exp_len;
         end
      end
   end

   // sequencer and bit timer registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ro_left_r <= '0;
         exp_cnt_r <= '0;
         off_r <= 23'h00_0000;
         row_r <= 16'h0000;
         bpos_r <= 8'h00;
         frames_left_r <= 16'h0000;
         fot_pend_r <= 1'b0;
         ext_wait_r <= 1'b0;
         te_pend_r <= 1'b0;
         fr_pend_r <= 1'b0;
         bc_r <= 8'h00;
         bi_r <= 4'h0;
      end else begin
         ro_left_r <= ro_left_nxt;
         exp_cnt_r <= exp_cnt_nxt;
         off_r <= off_nxt;
         row_r <= row_nxt;
         bpos_r <= bpos_nxt;
         frames_left_r <= frames_left_nxt;
         fot_pend_r <= fot_pend_nxt;
         ext_wait_r <= ext_wait_nxt;
         te_pend_r <= te_pend_nxt;
         fr_pend_r <= fr_pend_nxt;
         bc_r <= bit_end ? 8'h00 : bc_r + 8'h01;
         bi_r <= wt ? 4'h0 : (bit_end ? bi_r + 4'h1 : bi_r);
      end
   end

   // words for the next slot
   wire [11:0] tp2 = {4'h0, ~tp_r[7:0]};
   wire [11:0] cword = {4'h0, 1'b1, 1'b0, integ, integ, frame_overhead, frame_valid_flag, row_valid_flag, pixel_valid_flag};

   // link clock high in even bits; output and lanes come straight from flops
   logic lclk_r;
   logic [11:0] csh_r;
   logic busy_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lclk_r <= 1'b1;
         csh_r <= scet_pkg::CW_IDLE;
         busy_r <= 1'b0;
      end else begin
         if (bit_end) begin
            lclk_r <= wt | bi_r[0];
         end
         if (wt) begin
            csh_r <= cword;
         end else if (bit_end) begin
            csh_r <= csh_r >> 1;
         end
         busy_r <= fot_pend_r | integ | (ro_left_r != '0);
      end
   end
   assign lnk.lclk = lclk_r;
   assign lnk.ctrl_lane = csh_r[0];
   assign frame_busy = busy_r;

   // one serialiser per data lane; pixels are a lane/position test pattern
   genvar l;
   generate
      for (l = 0; l < LANES; l++) begin : g_lane
         localparam logic [3:0] LID = 4'(l);
         logic [11:0] sh_r;
         wire [11:0] word = pixel_valid_flag ? {LID, bpos_r} : (tp2_sel ? tp2 : tp_r);
         always_ff @(posedge core_clk) begin
            if (rst) begin
               sh_r <= 12'h000;
            end else if (wt) begin
               sh_r <= word;
            end else if (bit_end) begin
               sh_r <= sh_r >> 1;
            end
         end
         assign lnk.data_lane[l] = sh_r[0];
      end
   endgenerate
endmodule
`default_nettype wire

// [hdl/scet_pkg.sv]
// shared constants for the sensor control word, training pattern and exposure timing link
package scet_pkg;
   // word geometry
   localparam int WL_MAX = 12;
   localparam int AW = 7;
   localparam int DW = 16;
   localparam int CW = 48;
   localparam int BURST = 128;
   localparam int OV_MULT = 34;
   localparam int FOT_ADD = 2;
   // control word bit positions
   localparam int CB_PIX = 0;
   localparam int CB_ROW = 1;
   localparam int CB_FRM = 2;
   localparam int CB_FOT = 3;
   localparam int CB_INTA = 4;
   localparam int CB_INTB = 5;
   localparam int CB_ZERO = 6;
   localparam int CB_ONE = 7;
   localparam logic [11:0] CW_IDLE = 12'h080;
   // device register addresses
   localparam logic [6:0] A_LINES = 7'h01;
   localparam logic [6:0] A_EXP_MODE = 7'h46;
   localparam logic [6:0] A_EXP_LO = 7'h47;
   localparam logic [6:0] A_EXP_HI = 7'h48;
   localparam logic [6:0] A_FRAMES = 7'h50;
   localparam logic [6:0] A_LANES = 7'h51;
   localparam logic [6:0] A_OVH = 7'h52;
   localparam logic [6:0] A_LINE = 7'h55;
   localparam logic [6:0] A_TP = 7'h59;
   localparam logic [6:0] A_DEPTH = 7'h76;
   localparam logic [6:0] A_RDMODE = 7'h77;
   // device register reset values
   localparam logic [15:0] R_LINES = 16'h0C00;
   localparam logic [7:0] R_EXP_MODE = 8'h00;
   localparam logic [15:0] R_EXP_LO = 16'h0600;
   localparam logic [7:0] R_EXP_HI = 8'h00;
   localparam logic [15:0] R_FRAMES = 16'h0001;
   localparam logic [3:0] R_LANES = 4'h0;
   localparam logic [15:0] R_OVH = 16'h0C01;
   localparam logic [15:0] R_LINE = 16'h0080;
   localparam logic [11:0] R_TP = 12'h055;
   localparam logic [1:0] R_DEPTH = 2'h1;
   localparam logic [1:0] R_RDMODE = 2'h0;
   // bit depth codes
   localparam logic [1:0] DEP_8 = 2'h0;
   localparam logic [1:0] DEP_10 = 2'h1;
   // link timing in core clock cycles
   localparam int BIT_CYC = 4;
   localparam int WR_GAP = 8;
   localparam int PULSE_CYC = 8;
   // controller avalon word offsets
   localparam logic [2:0] O_DADDR = 3'h0;
   localparam logic [2:0] O_DDATA = 3'h1;
   localparam logic [2:0] O_CTRL = 3'h2;
   localparam logic [2:0] O_STAT = 3'h3;
   localparam logic [2:0] O_FCNT = 3'h4;
   localparam logic [2:0] O_LAST = 3'h5;
   // controller command bits
   localparam int C_SEND = 0;
   localparam int C_TEXP = 1;
   localparam int C_FREQ = 2;
   localparam int C_ALIGN = 3;
   localparam int C_WL = 4;
endpackage

// [hdl/scet_link_if.sv]
// link between the sensor device end and the receiver/controller end
`timescale 1ns/1ps
`default_nettype none
interface scet_link_if #(parameter int LANES = 64);
   // serial link
   logic lclk;
   logic ctrl_lane;
   logic [LANES-1:0] data_lane;
   // register load port, toggle-qualified
   logic reg_wr_tgl;
   logic [scet_pkg::AW-1:0] reg_addr;
   logic [scet_pkg::DW-1:0] reg_wdata;
   // trigger pins
   logic exposure_start_pin;
   logic frame_req_pin;
   modport dev (output lclk, ctrl_lane, data_lane,
      input reg_wr_tgl, reg_addr, reg_wdata, exposure_start_pin, frame_req_pin);
   modport ctl (input lclk, ctrl_lane, data_lane,
      output reg_wr_tgl, reg_addr, reg_wdata, exposure_start_pin, frame_req_pin);
endinterface
`default_nettype wire

// [hdl/scet_rx_ctrl.sv]
// controller end: avalon registers, device register loader, trigger pins, lane receiver
`timescale 1ns/1ps
`default_nettype none
module scet_rx_ctrl #(
   parameter int WR_GAP = scet_pkg::WR_GAP,
   parameter int PULSE_CYC = scet_pkg::PULSE_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // sensor link
   scet_link_if.ctl lnk
);
   // one wait cycle, then the request is taken at the edge that sees waitrequest low
   wire req = avs_read | avs_write;
   wire wr_take = avs_write && !avs_waitrequest;
   wire ctrl_wr = wr_take && avs_address == scet_pkg::O_CTRL;

   logic [6:0] dev_addr_r;
   logic [15:0] dev_data_r;
   logic [1:0] wl_r;
   logic tgl_r;
   logic [7:0] gap_r;
   logic [7:0] te_cnt_r;
   logic [7:0] fr_cnt_r;
   logic te_pin_r;
   logic fr_pin_r;
   wire busy = gap_r != 8'h00;

   // device register loads and trigger pulses
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dev_addr_r <= 7'h00;
         dev_data_r <= 16'h0000;
         wl_r <= scet_pkg::R_DEPTH;
         tgl_r <= 1'b0;
         gap_r <= 8'h00;
         te_cnt_r <= 8'h00;
         fr_cnt_r <= 8'h00;
         te_pin_r <= 1'b0;
         fr_pin_r <= 1'b0;
      end else begin
         if (wr_take && !busy && avs_address == scet_pkg::O_DADDR) begin
            dev_addr_r <= avs_writedata[6:0];
         end
         if (wr_take && !busy && avs_address == scet_pkg::O_DDATA) begin
            dev_data_r <= avs_writedata[15:0];
         end
         if (ctrl_wr) begin
            wl_r <= avs_writedata[scet_pkg::C_WL +: 2];
         end
         if (ctrl_wr && avs_writedata[scet_pkg::C_SEND] && !busy) begin
            tgl_r <= ~tgl_r;
            gap_r <= 8'(WR_GAP);
         end else if (busy) begin
            gap_r <= gap_r - 8'h01;
         end
         if (ctrl_wr && avs_writedata[scet_pkg::C_TEXP]) begin
            te_cnt_r <= 8'(PULSE_CYC);
            te_pin_r <= 1'b1;
         end else if (te_cnt_r != 8'h00) begin
            te_cnt_r <= te_cnt_r - 8'h01;
            te_pin_r <= te_cnt_r > 8'h01;
         end
         if (ctrl_wr && avs_writedata[scet_pkg::C_FREQ]) begin
            fr_cnt_r <= 8'(PULSE_CYC);
            fr_pin_r <= 1'b1;
         end else if (fr_cnt_r != 8'h00) begin
            fr_cnt_r <= fr_cnt_r - 8'h01;
            fr_pin_r <= fr_cnt_r > 8'h01;
         end
      end
   end
   assign lnk.reg_wr_tgl = tgl_r;
   assign lnk.reg_addr = dev_addr_r;
   assign lnk.reg_wdata = dev_data_r;
   assign lnk.exposure_start_pin = te_pin_r;
   assign lnk.frame_req_pin = fr_pin_r;

   // link pins cross in through two flops; clock edges found on the synced copy
   logic [2:0] ls;
   logic [1:0] cs;
   logic [1:0] ds;
   logic [11:0] csh_r;
   logic [11:0] dsh_r;
   logic [3:0] bcnt_r;
   logic locked_r;
   logic [11:0] cword_r;
   logic [11:0] pix_r;
   logic [15:0] fcnt_r;
   wire [3:0] wl = (wl_r == scet_pkg::DEP_8) ? 4'h8 : (wl_r == scet_pkg::DEP_10) ? 4'hA : 4'hC;
   wire ledge = ls[1] ^ ls[2];
   wire [11:0] csh_n = {cs[1], csh_r[11:1]};
   wire [11:0] dsh_n = {ds[1], dsh_r[11:1]};
   wire [11:0] cw = csh_n >> (4'hC - wl);
   wire [11:0] dw = dsh_n >> (4'hC - wl);
   wire wdone = ledge && (locked_r ? (bcnt_r == wl - 4'h1) : (cw == scet_pkg::CW_IDLE));
   wire bad = cw[scet_pkg::CB_ONE] != 1'b1 || cw[scet_pkg::CB_ZERO] != 1'b0;
   wire realign = ctrl_wr && avs_writedata[scet_pkg::C_ALIGN];

   // word alignment locks on the idle control word, lsb first
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ls <= 3'h0;
         cs <= 2'h0;
         ds <= 2'h0;
         csh_r <= 12'h000;
         dsh_r <= 12'h000;
         bcnt_r <= 4'h0;
         locked_r <= 1'b0;
         cword_r <= 12'h000;
         pix_r <= 12'h000;
         fcnt_r <= 16'h0000;
      end else begin
         ls <= {ls[1:0], lnk.lclk};
         cs <= {cs[0], lnk.ctrl_lane};
         ds <= {ds[0], lnk.data_lane[0]};
         if (ledge) begin
            csh_r <= csh_n;
            dsh_r <= dsh_n;
            bcnt_r <= wdone ? 4'h0 : bcnt_r + 4'h1;
         end
         if (realign) begin
            locked_r <= 1'b0;
         end else if (wdone) begin
            locked_r <= !(locked_r && bad);
         end
         if (wdone) begin
            cword_r <= cw;
            if (cw[scet_pkg::CB_PIX] && cw[scet_pkg::CB_ROW] && cw[scet_pkg::CB_FRM]) begin
               pix_r <= dw;
            end
            if (cword_r[scet_pkg::CB_FRM] && !cw[scet_pkg::CB_FRM]) begin
               fcnt_r <= fcnt_r + 16'h0001;
            end
         end
      end
   end

   // read selection
   wire [31:0] rd_stat = {30'h0000_0000, locked_r, busy};
   wire [31:0] rd_mux = (avs_address == scet_pkg::O_DADDR) ? {25'h000_0000, dev_addr_r} :
      (avs_address == scet_pkg::O_DDATA) ? {16'h0000, dev_data_r} :
      (avs_address == scet_pkg::O_CTRL) ? {26'h000_0000, wl_r, 4'h0} :
      (avs_address == scet_pkg::O_STAT) ? rd_stat :
      (avs_address == scet_pkg::O_FCNT) ? {16'h0000, fcnt_r} :
      (avs_address == scet_pkg::O_LAST) ? {4'h0, cword_r, 4'h0, pix_r} : 32'h0000_0000;

   // avalon handshake
   always_ff @(posedge core_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !(req && avs_waitrequest);
         if (req && avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/scet_properties.sv]
// checker for the sensor link: lane timing, control word, training words, trigger and load pins
`timescale 1ns/1ps
`default_nettype none
module scet_properties #(parameter int WL = 10) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // serial link
   input wire logic lclk,
   input wire logic ctrl_lane,
   input wire logic [63:0] data_lane,
   // register load and trigger pins
   input wire logic reg_wr_tgl,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic exposure_start_pin,
   input wire logic frame_req_pin
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic lc_r, c_r, d_r, tg_r, wd_r;
   logic [3:0] bc_r;
   logic [1:0] q_r;
   logic [7:0] pc_r;
   logic [WL-1:0] cw_r, dw_r, pw_r, pd_r;
   logic [11:0] tp_r;
   wire logic [11:0] tp2 = {4'h0, ~tp_r[7:0]};
   wire logic lend = lclk != lc_r;
   wire logic q0 = q_r == 2'h0;
   // rebuild words from reset release; checks pause three words after a load, which lands late
   always_ff @(posedge core_clk) begin
      lc_r <= lclk;
      c_r <= ctrl_lane;
      d_r <= data_lane[0];
      tg_r <= reg_wr_tgl;
      wd_r <= lend && bc_r == 4'(WL-1);
      if (rst) begin
         bc_r <= 4'h0;
         q_r <= 2'h3;
         pc_r <= 8'h00;
         tp_r <= scet_pkg::R_TP;
      end else begin
         if (lend) begin
            cw_r <= {c_r, cw_r[WL-1:1]};
            dw_r <= {d_r, dw_r[WL-1:1]};
            bc_r <= (bc_r == 4'(WL-1)) ? 4'h0 : bc_r + 4'h1;
         end
         if (wd_r) begin
            pw_r <= cw_r;
            pd_r <= dw_r;
            pc_r <= cw_r[0] ? pc_r + 8'h01 : 8'h00;
         end
         if (reg_wr_tgl != tg_r) begin
            q_r <= 2'h3;
            if (reg_addr == scet_pkg::A_TP) tp_r <= reg_wdata[11:0];
         end else if (wd_r && !q0) q_r <= q_r - 2'h1;
      end
   end
   property p_lclk_hi; $rose(lclk) |-> lclk[*4] ##1 !lclk; endproperty
   a_lclk_hi: assert property (p_lclk_hi) else $error("link clock high phase wrong");
   property p_lane_edge; !$stable({ctrl_lane, data_lane[0]}) |-> !$stable(lclk); endproperty
   a_lane_edge: assert property (p_lane_edge) else $error("lane moved off a bit edge");
   property p_ctl_const; wd_r |-> cw_r[7] && !cw_r[6] && cw_r[WL-1:8] == 0; endproperty
   a_ctl_const: assert property (p_ctl_const) else $error("control constants wrong");
   property p_flag_nest; wd_r && cw_r[0] |-> cw_r[1] && cw_r[2]; endproperty
   a_flag_nest: assert property (p_flag_nest) else $error("pixel flag outside row");
   property p_row_tp; wd_r && q0 && cw_r[1] && !cw_r[0] |-> dw_r == tp_r[WL-1:0]; endproperty
   a_row_tp: assert property (p_row_tp) else $error("row gap word wrong");
   property p_sec; wd_r && q0 && cw_r[1] && !pw_r[1] |-> pd_r == tp2[WL-1:0]; endproperty
   a_sec: assert property (p_sec) else $error("word before row wrong");
   property p_idle_tp; wd_r && q0 && !pw_r[1] && !cw_r[1] |-> pd_r == tp_r[WL-1:0]; endproperty
   a_idle_tp: assert property (p_idle_tp) else $error("idle data word wrong");
   property p_burst; wd_r && cw_r[0] |-> pc_r < 8'h80; endproperty
   a_burst: assert property (p_burst) else $error("pixel burst too long");
   property p_exp_pulse; $rose(exposure_start_pin) |-> exposure_start_pin[*8] ##1 !exposure_start_pin; endproperty
   a_exp_pulse: assert property (p_exp_pulse) else $error("exposure pulse length wrong");
   property p_req_pulse; $rose(frame_req_pin) |-> frame_req_pin[*8] ##1 !frame_req_pin; endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request pulse length wrong");
   property p_reg_hold;
      $changed(reg_wr_tgl) |=> (!$changed(reg_wr_tgl) && $stable(reg_addr) && $stable(reg_wdata))[*7];
   endproperty
   a_reg_hold: assert property (p_reg_hold) else $error("register load not held");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench: both link ends joined, driven from the avalon side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] avs_address = 3'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, rd, c0;
   logic avs_waitrequest, frame_busy;
   int n_mismatch = 0;
   int comparisons = 0;
   scet_link_if #(.LANES(64)) lnk ();
   scet_sensor_dev scet_sensor_dev_i (.core_clk(core_clk), .rst(rst), .lnk(lnk), .frame_busy(frame_busy));
   scet_rx_ctrl scet_rx_ctrl_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .lnk(lnk));
   scet_properties scet_properties_i (.core_clk(core_clk), .rst(rst), .lclk(lnk.lclk), .ctrl_lane(lnk.ctrl_lane),
      .data_lane(lnk.data_lane), .reg_wr_tgl(lnk.reg_wr_tgl), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
      .exposure_start_pin(lnk.exposure_start_pin), .frame_req_pin(lnk.frame_req_pin));
   always #5 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon cycle; request held until waitrequest is sampled low
   task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask
   // device register load, then wait out the send gap
   task automatic dwr(input logic [6:0] a, input logic [15:0] d);
      av(1'b1, scet_pkg::O_DADDR, {25'h0, a});
      av(1'b1, scet_pkg::O_DDATA, {16'h0000, d});
      av(1'b1, scet_pkg::O_CTRL, 32'h0000_0011);
      repeat (16) @(posedge core_clk);
   endtask
   // issue a command, wait for the frame work to end, compare frames counted
   task automatic frame(input logic [31:0] cmd, input logic [31:0] nf);
      av(1'b0, scet_pkg::O_FCNT, 32'h0);
      c0 = rd;
      av(1'b1, scet_pkg::O_CTRL, cmd);
      while (frame_busy !== 1'b1) @(posedge core_clk);
      while (frame_busy !== 1'b0) @(posedge core_clk);
      repeat (100) @(posedge core_clk);
      av(1'b0, scet_pkg::O_FCNT, 32'h0);
      chk(rd - c0, nf);
      av(1'b0, scet_pkg::O_LAST, 32'h0);
      chk(rd, 32'h0080_007F);
   endtask
   task automatic t_idle;
      av(1'b1, scet_pkg::O_CTRL, 32'h0000_0018);
      repeat (200) @(posedge core_clk);
      av(1'b0, scet_pkg::O_STAT, 32'h0);
      chk(rd & 32'h0000_0002, 32'h0000_0002);
      av(1'b0, scet_pkg::O_LAST, 32'h0);
      chk(rd & 32'hFFFF_0000, 32'h0080_0000);
      av(1'b1, 3'h6, 32'hFFFF_FFFF);
      av(1'b0, 3'h6, 32'h0);
      chk(rd, 32'h0000_0000);
   endtask
   // a data write while the first load is still in flight is refused
   task automatic t_tp;
      av(1'b1, scet_pkg::O_DADDR, {25'h0, scet_pkg::A_TP});
      av(1'b1, scet_pkg::O_DDATA, 32'h0000_03A5);
      av(1'b1, scet_pkg::O_CTRL, 32'h0000_0011);
      av(1'b0, scet_pkg::O_STAT, 32'h0);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      av(1'b1, scet_pkg::O_DDATA, 32'h0000_0111);
      av(1'b1, scet_pkg::O_CTRL, 32'h0000_0011);
      repeat (16) @(posedge core_clk);
      av(1'b0, scet_pkg::O_STAT, 32'h0);
      chk(rd & 32'h0000_0001, 32'h0000_0000);
      av(1'b0, scet_pkg::O_DDATA, 32'h0);
      chk(rd, 32'h0000_03A5);
   endtask
   task automatic t_int;
      dwr(scet_pkg::A_LINES, 16'h0002);
      dwr(scet_pkg::A_LINE, 16'h0081);
      dwr(scet_pkg::A_OVH, 16'h0001);
      dwr(scet_pkg::A_EXP_LO, 16'h0002);
      dwr(scet_pkg::A_FRAMES, 16'h0002);
      frame(32'h0000_0014, 32'h0000_0002);
   endtask
   task automatic t_ext;
      dwr(scet_pkg::A_EXP_MODE, 16'h0001);
      av(1'b1, scet_pkg::O_CTRL, 32'h0000_0012);
      repeat (400) @(posedge core_clk);
      frame(32'h0000_0014, 32'h0000_0001);
      dwr(scet_pkg::A_EXP_MODE, 16'h0000);
   endtask
   task automatic t_lanes;
      dwr(scet_pkg::A_FRAMES, 16'h0001);
      dwr(scet_pkg::A_LANES, 16'h0001);
      frame(32'h0000_0014, 32'h0000_0001);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_idle();
      t_tp();
      t_int();
      t_ext();
      t_lanes();
      final_report();
   end
   // watchdog: the frames above need over four fifths of this span
   initial begin
      #950000;
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
